//--- logic/ryp_packer.sv
`timescale 1ns/10ps
module ryp_packer (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire ryp_pkg::ryp_order_e order_sel_i,
    input wire logic pix_valid_i,
    output logic pix_ready_o,
    input wire logic [ryp_pkg::COMP_W-1:0] red_i,
    input wire logic [ryp_pkg::COMP_W-1:0] green_i,
    input wire logic [ryp_pkg::COMP_W-1:0] blue_i,
    output logic byte_valid_o,
    input wire logic byte_ready_i,
    output logic [ryp_pkg::COMP_W-1:0] byte_data_o
);
    import ryp_pkg::*;

    // ****************************************
    // conversion arithmetic
    // ****************************************

    // weighted sum with rounding, result in whole levels
    function automatic logic signed [19:0] mix(
        input logic signed [8:0] cr,
        input logic signed [8:0] cg,
        input logic signed [8:0] cb,
        input logic [7:0] r,
        input logic [7:0] g,
        input logic [7:0] b
    );
        logic signed [19:0] acc;
        acc = 20'(cr) * $signed({12'h000, r});
        acc = acc + 20'(cg) * $signed({12'h000, g});
        acc = acc + 20'(cb) * $signed({12'h000, b});
        acc = acc + ROUND_HALF;
        return acc >>> FRAC_BITS;
    endfunction

    // clamp luma into one unsigned byte
    function automatic logic [7:0] luma_code(input logic signed [19:0] q);
        logic [7:0] code;
        if (q < 0) begin
            code = CODE_MIN;
        end else if (q > LUMA_MAX) begin
            code = CODE_MAX;
        end else begin
            code = q[7:0];
        end
        return code;
    endfunction

    // clamp signed chroma, then shift to offset binary
    function automatic logic [7:0] chroma_code(input logic signed [19:0] q);
        logic [7:0] code;
        if (q > CHROMA_MAX) begin
            code = CODE_MAX;
        end else if (q < CHROMA_MIN) begin
            code = CODE_MIN;
        end else begin
            code = q[7:0] + CHROMA_OFFSET;
        end
        return code;
    endfunction

    // ****************************************
    // pair assembly state
    // ****************************************
    ryp_state_e state, next_state; // pair position
    ryp_order_e order, next_order; // order latched per pair
    logic [7:0] y0, next_y0; // luma of even pixel
    logic [7:0] y1, next_y1; // luma of odd pixel
    logic [7:0] u0, next_u0; // blue chroma of even pixel
    logic [7:0] v0, next_v0; // red chroma of even pixel
    logic [1:0] idx, next_idx; // byte within the pair
    logic accept; // pixel taken this cycle
    logic push; // byte offered to the buffer
    logic fifo_in_ready; // buffer has room
    logic [7:0] pair_byte; // byte chosen by order and idx
    logic [7:0] cur_y, cur_u, cur_v; // components of incoming pixel

    // component values are the same for both orders
    assign cur_y = luma_code(mix(Y_COEF_R, Y_COEF_G, Y_COEF_B, red_i, green_i, blue_i));
    assign cur_u = chroma_code(mix(U_COEF_R, U_COEF_G, U_COEF_B, red_i, green_i, blue_i));
    assign cur_v = chroma_code(mix(V_COEF_R, V_COEF_G, V_COEF_B, red_i, green_i, blue_i));

    // pixels are held off while a pair drains into the buffer
    assign pix_ready_o = (state != ST_SEND);
    assign accept = pix_valid_i && pix_ready_o;
    assign push = (state == ST_SEND);

    // byte selection, only the order differs between formats
    always_comb begin
        pair_byte = y0;
        if (order == ORDER_CHROMA_FIRST) begin
            case (idx)
                2'h0: pair_byte = u0;
                2'h1: pair_byte = y0;
                2'h2: pair_byte = v0;
                default: pair_byte = y1;
            endcase
        end else begin
            case (idx)
                2'h0: pair_byte = y0;
                2'h1: pair_byte = u0;
                2'h2: pair_byte = y1;
                default: pair_byte = v0;
            endcase
        end
    end

    // next state: even pixel gives luma and chroma, odd gives luma only
    always_comb begin
        next_state = state;
        next_order = order;
        next_y0 = y0;
        next_y1 = y1;
        next_u0 = u0;
        next_v0 = v0;
        next_idx = idx;
        case (state)
            ST_EVEN: begin
                if (accept) begin
                    next_y0 = cur_y;
                    next_u0 = cur_u;
                    next_v0 = cur_v;
                    next_order = order_sel_i; // no mixed orders within a pair
                    next_state = ST_ODD;
                end
            end
            ST_ODD: begin
                if (accept) begin
                    next_y1 = cur_y;
                    next_idx = 2'h0;
                    next_state = ST_SEND;
                end
            end
            ST_SEND: begin
                // a stalled buffer freezes the index, back pressure reaches the source
                if (fifo_in_ready) begin
                    next_idx = idx + 2'h1;
                    if (idx == LAST_BYTE) begin
                        next_state = ST_EVEN;
                    end
                end
            end
            default: begin
                next_state = ST_EVEN;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= ST_EVEN;
            order <= ORDER_CHROMA_FIRST;
            y0 <= CODE_MIN;
            y1 <= CODE_MIN;
            u0 <= CHROMA_OFFSET;
            v0 <= CHROMA_OFFSET;
            idx <= 2'h0;
        end else begin
            state <= next_state;
            order <= next_order;
            y0 <= next_y0;
            y1 <= next_y1;
            u0 <= next_u0;
            v0 <= next_v0;
            idx <= next_idx;
        end
    end

    // ****************************************
    // output buffer
    // ****************************************
    ryp_fifo #(
        .WIDTH(COMP_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .in_valid_i(push),
        .in_ready_o(fifo_in_ready),
        .in_data_i(pair_byte),
        .out_valid_o(byte_valid_o),
        .out_ready_i(byte_ready_i),
        .out_data_o(byte_data_o)
    );

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    logic white_in, black_in, blue_in, red_in; // probe pixels
    assign white_in = (red_i == 8'hff) && (green_i == 8'hff) && (blue_i == 8'hff);
    assign black_in = (red_i == 8'h00) && (green_i == 8'h00) && (blue_i == 8'h00);
    assign blue_in = (red_i == 8'h00) && (green_i == 8'h00) && (blue_i == 8'hff);
    assign red_in = (red_i == 8'hff) && (green_i == 8'h00) && (blue_i == 8'h00);

    a_odd_starts_send: assert property (
        (state == ST_ODD) && accept |=> (state == ST_SEND) && (idx == 2'h0) && !pix_ready_o)
        else $error("odd pixel did not start a four byte send");
    a_send_four_bytes: assert property (
        (state == ST_ODD) && accept ##1 fifo_in_ready [*4] |=> (state == ST_EVEN))
        else $error("pair did not drain in four bytes");
    a_chroma_first_u: assert property (
        push && (order == ORDER_CHROMA_FIRST) && (idx == 2'h0) |-> (pair_byte == u0))
        else $error("chroma first order does not open with blue chroma");
    a_chroma_first_y1: assert property (
        push && (order == ORDER_CHROMA_FIRST) && (idx == 2'h3) |-> (pair_byte == y1))
        else $error("chroma first order does not close with odd luma");
    a_luma_first_u: assert property (
        push && (order == ORDER_LUMA_FIRST) && (idx == 2'h1) |-> (pair_byte == u0))
        else $error("luma first order second byte is not blue chroma");
    a_luma_first_v: assert property (
        push && (order == ORDER_LUMA_FIRST) && (idx == 2'h3) |-> (pair_byte == v0))
        else $error("luma first order last byte is not red chroma");
    a_order_held: assert property (
        (state != ST_EVEN) |=> (order == $past(order)))
        else $error("byte order changed in the middle of a pair");
    a_luma_white: assert property (
        (state == ST_EVEN) && accept && white_in |=> (y0 == 8'hff) && (u0 == 8'h80))
        else $error("white pixel gave wrong codes");
    a_black_levels: assert property (
        (state == ST_EVEN) && accept && black_in |=> (y0 == 8'h00) && (v0 == 8'h80))
        else $error("black pixel gave wrong codes");
    a_blue_sat: assert property (
        (state == ST_EVEN) && accept && blue_in |=> (u0 == 8'hff) && (y0 == 8'h1c))
        else $error("pure blue pixel gave wrong codes");
    a_red_sat: assert property (
        (state == ST_EVEN) && accept && red_in |=> (v0 == 8'hff) && (u0 == 8'h54))
        else $error("pure red pixel gave wrong codes");

    c_pair_chroma: cover property (
        push && (order == ORDER_CHROMA_FIRST) && (idx == 2'h3) && fifo_in_ready);
    c_pair_luma: cover property (
        push && (order == ORDER_LUMA_FIRST) && (idx == 2'h3) && fifo_in_ready);
    c_buffer_full: cover property (push && !fifo_in_ready);
endmodule

//--- logic/ryp_pkg.sv
// Operation
// - accept full red, green, blue per pixel
// - luma = 0.30 R + 0.59 G + 0.11 B
// - blue chroma = -0.17 R - 0.33 G + 0.50 B
// - red chroma = 0.50 R - 0.41 G - 0.09 B
// - add 128 so chroma spans 0 to 255
// - chroma offset binary, 0x80 is zero
// - luma unsigned byte, 0x00 to 0xff
// - chroma-first order: U0 Y0 V0 Y1
// - luma every pixel, chroma from even pixel
// - luma-first order: Y0 U0 Y1 V0
// - both orders carry identical component values
package ryp_pkg;

    // ****************************************
    // coefficients, scaled by 256
    // ****************************************
    localparam int FRAC_BITS = 8;                     // fixed point fraction bits
    localparam logic signed [8:0] Y_COEF_R = 9'sd77;  // 0.30 * 256
    localparam logic signed [8:0] Y_COEF_G = 9'sd151; // 0.59 * 256
    localparam logic signed [8:0] Y_COEF_B = 9'sd28;  // 0.11 * 256
    localparam logic signed [8:0] U_COEF_R = -9'sd44; // -0.17 * 256
    localparam logic signed [8:0] U_COEF_G = -9'sd84; // -0.33 * 256
    localparam logic signed [8:0] U_COEF_B = 9'sd128; // 0.50 * 256
    localparam logic signed [8:0] V_COEF_R = 9'sd128; // 0.50 * 256
    localparam logic signed [8:0] V_COEF_G = -9'sd105; // -0.41 * 256
    localparam logic signed [8:0] V_COEF_B = -9'sd23; // -0.09 * 256
    localparam logic signed [19:0] ROUND_HALF = 20'sd128; // half an lsb before shift

    // ****************************************
    // code limits
    // ****************************************
    localparam logic signed [19:0] LUMA_MAX = 20'sd255;
    localparam logic signed [19:0] CHROMA_MAX = 20'sd127;
    localparam logic signed [19:0] CHROMA_MIN = -20'sd128;
    localparam logic [7:0] CHROMA_OFFSET = 8'h80; // level zero code
    localparam logic [7:0] CODE_MAX = 8'hff;
    localparam logic [7:0] CODE_MIN = 8'h00;

    // ****************************************
    // stream shape
    // ****************************************
    localparam int COMP_W = 8;     // bits per colour component
    localparam int FIFO_DEPTH = 32; // words in the output buffer
    localparam logic [1:0] LAST_BYTE = 2'h3; // fourth byte of a pair

    // byte orders of a pixel pair
    typedef enum logic {
        ORDER_CHROMA_FIRST = 1'b0, // chroma_first_pair_order
        ORDER_LUMA_FIRST = 1'b1    // luma_first_pair_order
    } ryp_order_e;

    // pair assembly states
    typedef enum logic [2:0] {
        ST_EVEN = 3'b001, // waiting for even pixel
        ST_ODD = 3'b010,  // waiting for odd pixel
        ST_SEND = 3'b100  // pushing four bytes
    } ryp_state_e;

endpackage

//--- logic/ryp_fifo.sv
`timescale 1ns/10ps
module ryp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH]; // storage flops
    logic [AW-1:0] wr_ptr, next_wr_ptr;
    logic [AW-1:0] rd_ptr, next_rd_ptr;
    logic [AW:0] count, next_count; // words held
    logic wr_en, rd_en;

    // honest flags straight from the count
    assign in_ready_o = (count != FULL_CNT);
    assign out_valid_o = (count != '0);
    assign out_data_o = mem[rd_ptr];

    // ****************************************
    // pointer and count update
    // ****************************************
    always_comb begin
        wr_en = in_valid_i && in_ready_o;
        rd_en = out_valid_o && out_ready_i;
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count = count;
        if (wr_en) begin
            // wrap by compare, depth need not be a power of two
            next_wr_ptr = (wr_ptr == LAST_IDX) ? '0 : wr_ptr + 1'b1;
        end
        if (rd_en) begin
            next_rd_ptr = (rd_ptr == LAST_IDX) ? '0 : rd_ptr + 1'b1;
        end
        if (wr_en && !rd_en) begin
            next_count = count + 1'b1;
        end else if (rd_en && !wr_en) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

    // data words carry no reset, only the pointers and count matter
    always_ff @(posedge sys_clk_i) begin
        if (wr_en) begin
            mem[wr_ptr] <= in_data_i;
        end
    end
endmodule

//--- test/ryp_sink.sv
`timescale 1ns/10ps
// ****************************************
// downstream byte sink, stands in for the transmit path
// ****************************************
module ryp_sink (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic stall_i, // hold ready low so the buffer fills
    input wire logic slow_i, // take a byte only every second cycle
    input wire logic byte_valid_i,
    output logic byte_ready_o,
    input wire logic [ryp_pkg::COMP_W-1:0] byte_data_i
);
    import ryp_pkg::*;
    logic [COMP_W-1:0] got [$]; // bytes taken, in arrival order
    // ready moves just after an edge, never in mid-cycle
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            byte_ready_o <= 1'b0;
        end else begin
            byte_ready_o <= !stall_i && (!slow_i || !byte_ready_o);
        end
    end
    // a byte counts only at an edge where valid and ready are both high
    always @(posedge sys_clk_i) begin
        if (!rst_i && byte_valid_i === 1'b1 && byte_ready_o) begin
            got.push_back(byte_data_i);
        end
    end
endmodule

//--- test/ryp_packer_test.sv
`timescale 1ns/10ps
module ryp_packer_test;
    import ryp_pkg::*;
    // ****************************************
    // stimulus and observed signals
    // ****************************************
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    ryp_order_e order_sel = ORDER_CHROMA_FIRST;
    logic pix_valid = 1'b0;
    logic [7:0] red = 8'h00, green = 8'h00, blue = 8'h00;
    logic stall = 1'b0, slow = 1'b0; // sink pacing
    logic pix_ready, byte_valid, byte_ready;
    logic [7:0] byte_data;
    int fails = 0, n_checks = 0;
    logic [7:0] exp_q [$]; // bytes the sink should see
    // colours: white black blue red green cyan grey yellow
    localparam logic [7:0] PX [8][3] = '{'{8'hff, 8'hff, 8'hff}, '{8'h00, 8'h00, 8'h00},
        '{8'h00, 8'h00, 8'hff}, '{8'hff, 8'h00, 8'h00}, '{8'h00, 8'hff, 8'h00},
        '{8'h00, 8'hff, 8'hff}, '{8'h80, 8'h80, 8'h80}, '{8'hff, 8'hff, 8'h00}};

    ryp_packer uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .order_sel_i(order_sel),
        .pix_valid_i(pix_valid), .pix_ready_o(pix_ready), .red_i(red), .green_i(green),
        .blue_i(blue), .byte_valid_o(byte_valid), .byte_ready_i(byte_ready),
        .byte_data_o(byte_data));
    ryp_sink sink (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .stall_i(stall), .slow_i(slow),
        .byte_valid_i(byte_valid), .byte_ready_o(byte_ready), .byte_data_i(byte_data));

    // 50 MHz clock
    initial begin
        forever #10 sys_clk_i = ~sys_clk_i;
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task give_verdict;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            fails++;
        end
    endtask

    // a bound ran out: counted, then the run closes
    task too_long;
        $display("BAD t=%0t got=%h exp=%h", $time, 8'h00, 8'h01);
        fails++;
        give_verdict();
    endtask

    // scaled weighted sum, rounded half up, clamped, chroma offset
    function automatic logic [7:0] conv(input int cr, cg, cb, input int r, g, b, input bit ch);
        int s;
        s = (cr * r + cg * g + cb * b + 128) >>> 8;
        if (ch) begin
            s = (s > 127) ? 127 : ((s < -128) ? -128 : s);
            return 8'(s + 128);
        end
        return 8'((s > 255) ? 255 : ((s < 0) ? 0 : s));
    endfunction

    // hold the pixel until an edge sees ready high
    task send_pix(input int i);
        int k;
        red <= PX[i][0];
        green <= PX[i][1];
        blue <= PX[i][2];
        pix_valid <= 1'b1;
        k = 0;
        @(negedge sys_clk_i);
        while (pix_ready !== 1'b1) begin
            if (++k > 200) too_long();
            @(negedge sys_clk_i);
        end
        @(posedge sys_clk_i);
    endtask

    // an even pixel then an odd pixel, back to back, never half a pair
    task send_pair(input int a, input ryp_order_e ord);
        logic [7:0] y0, u, v, y1;
        y0 = conv(Y_COEF_R, Y_COEF_G, Y_COEF_B, PX[a][0], PX[a][1], PX[a][2], 0);
        u = conv(U_COEF_R, U_COEF_G, U_COEF_B, PX[a][0], PX[a][1], PX[a][2], 1);
        v = conv(V_COEF_R, V_COEF_G, V_COEF_B, PX[a][0], PX[a][1], PX[a][2], 1);
        y1 = conv(Y_COEF_R, Y_COEF_G, Y_COEF_B, PX[a+1][0], PX[a+1][1], PX[a+1][2], 0);
        if (ord == ORDER_CHROMA_FIRST) begin
            exp_q = {exp_q, u, y0, v, y1};
        end else begin
            exp_q = {exp_q, y0, u, y1, v};
        end
        // inputs move only at a rising edge, and valid never drops and rises in one step
        @(posedge sys_clk_i);
        order_sel <= ord;
        send_pix(a);
        send_pix(a + 1);
        pix_valid <= 1'b0;
    endtask

    // wait for every expected byte, compare, then clear both sides
    task check_all;
        int k;
        k = 0;
        while (sink.got.size() < exp_q.size()) begin
            if (++k > 2000) too_long();
            @(negedge sys_clk_i);
        end
        repeat (8) @(negedge sys_clk_i);
        chk(8'(sink.got.size()), 8'(exp_q.size()));
        foreach (exp_q[i]) begin
            chk(sink.got[i], exp_q[i]);
        end
        sink.got.delete();
        exp_q.delete();
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task t_chroma_first;
        for (int p = 0; p < 4; p++) begin
            send_pair(2 * p, ORDER_CHROMA_FIRST);
        end
        check_all();
        $display("test chroma_first done");
    endtask

    // same colours, other order, slow sink: values must not change
    task t_luma_first;
        slow <= 1'b1;
        for (int p = 0; p < 4; p++) begin
            send_pair(2 * p, ORDER_LUMA_FIRST);
        end
        check_all();
        slow <= 1'b0;
        $display("test luma_first done");
    endtask

    // order changes on every pair, latched at each even pixel
    task t_switch;
        for (int p = 0; p < 4; p++) begin
            send_pair(2 * p, ryp_order_e'(p[0]));
        end
        check_all();
        $display("test switch done");
    endtask

    // sink stalls: eight pairs fill the buffer, the ninth is held back
    task t_fill;
        stall <= 1'b1;
        for (int p = 0; p < 9; p++) begin
            send_pair(2 * (p % 4), ORDER_CHROMA_FIRST);
        end
        repeat (10) @(negedge sys_clk_i);
        chk({7'h00, pix_ready}, 8'h00);
        chk({7'h00, byte_valid}, 8'h01);
        chk(8'(sink.got.size()), 8'h00);
        stall <= 1'b0;
        slow <= 1'b1;
        check_all();
        slow <= 1'b0;
        $display("test fill done");
    endtask

    // reset in mid-run drops a pair before its bytes reach the buffer, then a fresh pair flows
    task t_reset;
        stall <= 1'b1;
        send_pair(2, ORDER_LUMA_FIRST);
        exp_q.delete();
        rst_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        stall <= 1'b0;
        @(negedge sys_clk_i);
        chk({7'h00, pix_ready}, 8'h01);
        chk({7'h00, byte_valid}, 8'h00);
        send_pair(6, ORDER_LUMA_FIRST);
        check_all();
        $display("test reset done");
    endtask

    // main sequence
    initial begin
        repeat (4) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        @(negedge sys_clk_i);
        chk({7'h00, pix_ready}, 8'h01);
        chk({7'h00, byte_valid}, 8'h00);
        t_chroma_first();
        t_luma_first();
        t_switch();
        t_fill();
        t_reset();
        give_verdict();
    end
endmodule
